// >>> hdl/scf_pkg.sv
/*
 * scf_pkg: shared constants for the status condition filter block.
 * Holds group bit positions, implemented-bit masks, group grouping
 * (latched versus level) and reset values. Assumes nothing of its users
 * beyond referencing every item as scf_pkg::name.
 */
`default_nettype none

package scf_pkg;
    // group counts; the short read form carries groups 4..1, the long one 8..1
    localparam int GROUPS = 8;
    localparam int HALF_GROUPS = 4;

    // group 1 (index 0): latched events
    localparam int G1_ADC_DONE = 0;
    localparam int G1_PRINT_TIMER = 2;
    localparam int G1_TIMED_LOG = 3;
    // group 2 (index 1): latched events
    localparam int G2_MEAS_DROP = 0;
    localparam int G2_UNIT_CHANGE = 1;
    localparam int G2_SYNTAX_ERR = 2;
    localparam int G2_EXEC_ERR = 3;
    // group 3 (index 2): levels
    localparam int G3_CHART_END = 1;
    localparam int G3_CARD_LOW = 2;
    localparam int G3_CHART_FEED = 5;
    // group 4 (index 3): levels
    localparam int G4_BASIC_SET = 0;
    localparam int G4_RECORDING = 1;
    localparam int G4_COMPUTING = 2;
    localparam int G4_ALARM = 3;
    localparam int G4_HEADER = 6;
    // group 7 (index 6): levels
    localparam int G7_SAVING = 0;
    localparam int G7_REPLAYING = 1;

    // implemented bits per group, group 8 first; unassigned bits stay zero
    localparam logic [7:0][7:0] GRP_MASK = {8'h00, 8'h03, 8'h00, 8'h00,
                                            8'h4F, 8'h26, 8'h0F, 8'h0D};

    // group indices of the latched groups (1,2,5,6) and level groups (3,4,7,8)
    localparam logic [3:0][2:0] LAT_GRP = {3'h5, 3'h4, 3'h1, 3'h0};
    localparam logic [3:0][2:0] LVL_GRP = {3'h7, 3'h6, 3'h3, 3'h2};

    // reset values
    localparam logic [7:0] FILTER_RST = 8'hFF;
    localparam logic [7:0] STATUS_RST = 8'h00;
endpackage

`default_nettype wire

// >>> hdl/scf_status_filter.sv
/*
 * scf_status_filter: condition register, per-connection filters and
 * per-connection latched status copies, with a status read port that
 * returns groups as raw bytes and as three-digit decimal digits.
 * Assumes all inputs are synchronous to clk, event inputs are one-cycle
 * pulses, level inputs are held for as long as the condition lasts, and
 * the command decoder in front presents one filter write and one status
 * read per cycle at most.
 */
`timescale 1ns/1ps
`default_nettype none

module scf_status_filter #(
    parameter int N_CONN = 2,                            // host connections
    parameter int CONN_W = (N_CONN > 1) ? $clog2(N_CONN) : 1
) (
    input wire logic clk,
    input wire logic reset,
    // one-cycle event pulses
    input wire logic adc_done,
    input wire logic print_timer_expired,
    input wire logic timed_log_timer_expired,
    input wire logic meas_drop,
    input wire logic unit_change,
    input wire logic cmd_syntax_err,
    input wire logic cmd_exec_err,
    // condition levels, and the header start and end pulses
    input wire logic chart_paper_out,
    input wire logic card_space_low,
    input wire logic chart_feed_active,
    input wire logic basic_setting_mode,
    input wire logic recording_active,
    input wire logic computing_active,
    input wire logic alarm_active,
    input wire logic header_print_start,
    input wire logic header_print_end,
    input wire logic card_saving,
    input wire logic card_replaying,
    // filter-setting command
    input wire logic filter_wr,
    input wire logic [CONN_W-1:0] filter_conn,
    input wire logic [2:0] filter_group,
    input wire logic [7:0] filter_data,
    // status-read command
    input wire logic status_rd,
    input wire logic [CONN_W-1:0] status_conn,
    input wire logic status_ext,
    // answer
    output logic status_valid,
    output logic status_ext_out,
    output logic [63:0] status_word,
    output logic [95:0] status_bcd
);

    localparam logic [CONN_W:0] CONN_LIMIT = (CONN_W + 1)'(N_CONN);

    // binary byte to three bcd digits (hundreds, tens, ones)
    function automatic logic [11:0] to_bcd(input logic [7:0] bin);
        logic [19:0] sh;
        int i;
        sh = {12'h000, bin};
        for (i = 0; i < 8; i++) begin
            if (sh[11:8] > 4'h4) sh[11:8] = sh[11:8] + 4'h3;
            if (sh[15:12] > 4'h4) sh[15:12] = sh[15:12] + 4'h3;
            if (sh[19:16] > 4'h4) sh[19:16] = sh[19:16] + 4'h3;
            sh = sh << 1;
        end
        return sh[19:8];
    endfunction

    logic header_active_reg;                   // start-to-end header window
    logic [7:0][7:0] cond;                     // condition register view
    logic [7:0][7:0] filter_reg [N_CONN];      // filter per connection
    logic [3:0][7:0] lat_reg [N_CONN];         // latched copy per connection
    logic [7:0][7:0] rd_view;                  // groups as seen by the reader
    logic rd_ok;                               // read names a real connection
    logic wr_ok;                               // write names a real connection
    logic status_valid_reg;
    logic status_ext_reg;
    logic [63:0] status_word_reg;
    logic [95:0] status_bcd_reg;

    assign rd_ok = status_rd && ({1'b0, status_conn} < CONN_LIMIT);
    assign wr_ok = filter_wr && ({1'b0, filter_conn} < CONN_LIMIT);

    // header window: the start pulse opens it, the end pulse closes it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            header_active_reg <= 1'b0;
        end else if (header_print_start) begin
            header_active_reg <= 1'b1;
        end else if (header_print_end) begin
            header_active_reg <= 1'b0;
        end
    end

    // condition register: events and levels in their group positions;
    // the final mask keeps every unassigned bit, and all of group 5, at zero
    always_comb begin
        cond = '0;
        cond[0][scf_pkg::G1_ADC_DONE] = adc_done;
        cond[0][scf_pkg::G1_PRINT_TIMER] = print_timer_expired;
        cond[0][scf_pkg::G1_TIMED_LOG] = timed_log_timer_expired;
        cond[1][scf_pkg::G2_MEAS_DROP] = meas_drop;
        cond[1][scf_pkg::G2_UNIT_CHANGE] = unit_change;
        cond[1][scf_pkg::G2_SYNTAX_ERR] = cmd_syntax_err;
        cond[1][scf_pkg::G2_EXEC_ERR] = cmd_exec_err;
        cond[2][scf_pkg::G3_CHART_END] = chart_paper_out;
        cond[2][scf_pkg::G3_CARD_LOW] = card_space_low;
        cond[2][scf_pkg::G3_CHART_FEED] = chart_feed_active;
        cond[3][scf_pkg::G4_BASIC_SET] = basic_setting_mode;
        cond[3][scf_pkg::G4_RECORDING] = recording_active;
        cond[3][scf_pkg::G4_COMPUTING] = computing_active;
        cond[3][scf_pkg::G4_ALARM] = alarm_active;
        cond[3][scf_pkg::G4_HEADER] = header_active_reg;
        cond[6][scf_pkg::G7_SAVING] = card_saving;
        cond[6][scf_pkg::G7_REPLAYING] = card_replaying;
        cond = cond & scf_pkg::GRP_MASK;
    end

    // filter store: one byte per group per connection; reset opens all bits
    // so a fresh connection sees everything until it narrows the filter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < N_CONN; c++) begin
                filter_reg[c] <= {8{scf_pkg::FILTER_RST}};
            end
        end else begin
            for (int c = 0; c < N_CONN; c++) begin
                if (wr_ok && (filter_conn == CONN_W'(c))) begin
                    filter_reg[c][filter_group] <= filter_data;
                end
            end
        end
    end

    // latched groups: event bits pass the filter before they are stored, so a
    // masked event never lands and cannot show up after unmasking; a read of
    // this connection clears the copy, but an event in that same cycle is
    // ORed in after the clear and survives to the next read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < N_CONN; c++) begin
                lat_reg[c] <= {4{scf_pkg::STATUS_RST}};
            end
        end else begin
            for (int c = 0; c < N_CONN; c++) begin
                for (int l = 0; l < 4; l++) begin
                    lat_reg[c][l] <=
                        ((rd_ok && (status_conn == CONN_W'(c))) ?
                            scf_pkg::STATUS_RST : lat_reg[c][l])
                        | (cond[scf_pkg::LAT_GRP[l]]
                           & filter_reg[c][scf_pkg::LAT_GRP[l]]);
                end
            end
        end
    end

    // reader view: latched groups from the copy, level groups straight from
    // the condition register gated by the filter, so a level hidden by the
    // filter is still tracked and appears as soon as the filter opens
    always_comb begin
        rd_view = '0;
        for (int l = 0; l < 4; l++) begin
            rd_view[scf_pkg::LAT_GRP[l]] = lat_reg[status_conn][l];
            rd_view[scf_pkg::LVL_GRP[l]] = cond[scf_pkg::LVL_GRP[l]]
                & filter_reg[status_conn][scf_pkg::LVL_GRP[l]];
        end
    end

    // answer strobe: one cycle after each accepted read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_valid_reg <= 1'b0;
            status_ext_reg <= 1'b0;
        end else begin
            status_valid_reg <= rd_ok;
            if (rd_ok) status_ext_reg <= status_ext;
        end
    end

    // answer data: group n in byte n-1, so the word prints high group first;
    // the short form leaves groups 5..8 at zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_word_reg <= '0;
            status_bcd_reg <= '0;
        end else if (rd_ok) begin
            for (int g = 0; g < scf_pkg::GROUPS; g++) begin
                if (status_ext || g < scf_pkg::HALF_GROUPS) begin
                    status_word_reg[g*8 +: 8] <= rd_view[g];
                    status_bcd_reg[g*12 +: 12] <= to_bcd(rd_view[g]);
                end else begin
                    status_word_reg[g*8 +: 8] <= 8'h00;
                    status_bcd_reg[g*12 +: 12] <= 12'h000;
                end
            end
        end
    end

    assign status_valid = status_valid_reg;
    assign status_ext_out = status_ext_reg;
    assign status_word = status_word_reg;
    assign status_bcd = status_bcd_reg;

    // latch and filter checks below watch connection 0, the level checks any read; the logic is the same loop for all
    sequence s_read0;
        rd_ok && (status_conn == CONN_W'(0));
    endsequence

    sequence s_no_events;
        !(adc_done || print_timer_expired || timed_log_timer_expired ||
          meas_drop || unit_change || cmd_syntax_err || cmd_exec_err);
    endsequence

    sequence s_header_open;
        header_print_start ##1 (!header_print_end && !header_print_start) [*2];
    endsequence

    property p_event_sets;
        @(posedge clk) disable iff (reset)
        adc_done && filter_reg[0][0][scf_pkg::G1_ADC_DONE]
        |=> lat_reg[0][0][scf_pkg::G1_ADC_DONE] ##1
            (lat_reg[0][0][scf_pkg::G1_ADC_DONE] || $past(rd_ok));
    endproperty
    a_event_sets: assert property (p_event_sets)
        else $error("filtered event did not latch");

    property p_masked_dropped;
        @(posedge clk) disable iff (reset)
        meas_drop && !filter_reg[0][1][scf_pkg::G2_MEAS_DROP]
            && !lat_reg[0][1][scf_pkg::G2_MEAS_DROP]
        |=> !lat_reg[0][1][scf_pkg::G2_MEAS_DROP];
    endproperty
    a_masked_dropped: assert property (p_masked_dropped)
        else $error("masked event reached latched group");

    property p_read_clears;
        @(posedge clk) disable iff (reset)
        s_read0 and s_no_events |=> (lat_reg[0] == '0);
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("latched groups not cleared by read");

    property p_set_wins;
        @(posedge clk) disable iff (reset)
        s_read0 and (cmd_exec_err && filter_reg[0][1][scf_pkg::G2_EXEC_ERR])
        |=> lat_reg[0][1][scf_pkg::G2_EXEC_ERR];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost under clearing read");

    property p_other_conn_kept;
        @(posedge clk) disable iff (reset)
        rd_ok && (status_conn != CONN_W'(0)) and s_no_events
        |=> (lat_reg[0] == $past(lat_reg[0]));
    endproperty
    a_other_conn_kept: assert property (p_other_conn_kept)
        else $error("read of another connection disturbed connection 0");

    property p_answer_timing;
        @(posedge clk) disable iff (reset)
        rd_ok |=> status_valid ##1 (status_valid == $past(rd_ok));
    endproperty
    a_answer_timing: assert property (p_answer_timing)
        else $error("status answer not one cycle after read");

    property p_level_report;
        @(posedge clk) disable iff (reset)
        rd_ok && recording_active
            && filter_reg[status_conn][3][scf_pkg::G4_RECORDING]
        |=> status_word[8*3 + scf_pkg::G4_RECORDING] ##1
            (!status_valid || status_word[8*3 + scf_pkg::G4_RECORDING]
             || !$past(recording_active) || $past(rd_ok));
    endproperty
    a_level_report: assert property (p_level_report)
        else $error("recording level not reported");

    property p_level_masked;
        @(posedge clk) disable iff (reset)
        rd_ok && !filter_reg[status_conn][2][scf_pkg::G3_CHART_END]
        |=> !status_word[8*2 + scf_pkg::G3_CHART_END];
    endproperty
    a_level_masked: assert property (p_level_masked)
        else $error("masked level bit reported");

    property p_filter_store;
        @(posedge clk) disable iff (reset)
        wr_ok && (filter_conn == CONN_W'(0))
        |=> (filter_reg[0][$past(filter_group)] == $past(filter_data));
    endproperty
    a_filter_store: assert property (p_filter_store)
        else $error("filter write not stored");

    property p_reserved_zero;
        @(posedge clk) disable iff (reset)
        status_valid |-> (status_word[39:32] == 8'h00) && (status_word[47:40] == 8'h00)
            && ((status_word & ~64'(scf_pkg::GRP_MASK)) == 64'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("unassigned status bit set");

    property p_short_form;
        @(posedge clk) disable iff (reset)
        status_valid && !status_ext_out |-> (status_word[63:32] == 32'h0);
    endproperty
    a_short_form: assert property (p_short_form)
        else $error("short form carried upper groups");

    property p_bcd_value;
        @(posedge clk) disable iff (reset)
        status_valid |-> (status_bcd[11:8] <= 4'h2) && (status_bcd[7:4] <= 4'h9)
            && (status_bcd[3:0] <= 4'h9)
            && ((10'(status_bcd[11:8]) * 10'd100 + 10'(status_bcd[7:4]) * 10'd10
                 + 10'(status_bcd[3:0])) == {2'b00, status_word[7:0]});
    endproperty
    a_bcd_value: assert property (p_bcd_value)
        else $error("decimal digits disagree with group 1");

    property p_header_window;
        @(posedge clk) disable iff (reset)
        s_header_open |-> header_active_reg ##1 (header_active_reg || $past(header_print_end));
    endproperty
    a_header_window: assert property (p_header_window)
        else $error("header bit dropped inside header window");

endmodule // scf_status_filter

`default_nettype wire

// >>> test/scf_host_model.sv
/*
 * scf_host_model: host side of the command link, issuing filter-setting
 * and status-read commands to the status condition filter.
 * Assumes one clock; commands change only at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module scf_host_model #(
    parameter int CONN_W = 2
) (
    input wire logic clk,
    output logic filter_wr,
    output logic [CONN_W-1:0] filter_conn,
    output logic [2:0] filter_group,
    output logic [7:0] filter_data,
    output logic status_rd,
    output logic [CONN_W-1:0] status_conn,
    output logic status_ext
);
    // idle command lines at time zero
    initial begin
        filter_wr = 1'h0;
        filter_conn = '0;
        filter_group = 3'h0;
        filter_data = 8'h00;
        status_rd = 1'h0;
        status_conn = '0;
        status_ext = 1'h0;
    end

    // filter-setting command, strobe held for one cycle
    task automatic set_filter(input logic [CONN_W-1:0] c, input logic [2:0] g,
                              input logic [7:0] d);
        @(negedge clk);
        filter_wr = 1'h1;
        filter_conn = c;
        filter_group = g;
        filter_data = d;
        @(negedge clk);
        filter_wr = 1'h0;
        // idle byte inverted so a stale mask is never mistaken for a write
        filter_data = ~d;
    endtask

    // status-read command in short or extended form
    task automatic read_status(input logic [CONN_W-1:0] c, input logic e);
        @(negedge clk);
        status_rd = 1'h1;
        status_conn = c;
        status_ext = e;
        @(negedge clk);
        status_rd = 1'h0;
        status_ext = ~e;
    endtask
endmodule // scf_host_model

`default_nettype wire

// >>> test/tb_top.sv
/*
 * tb_top: self-checking bench for scf_status_filter with a clocked
 * reference model that notes each expected answer in a queue.
 * Assumes the host model drives commands at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int NC = 3; // three connections, so index 3 is refused
    localparam int CW = 2;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [6:0] ev = '0; // event pulses
    logic [8:0] lv = '0; // condition levels
    logic hs = 1'h0; // header start pulse
    logic he = 1'h0; // header end pulse
    logic fwr, srd, sext, sval, sxo;
    logic [CW-1:0] fcn, scn;
    logic [2:0] fgr;
    logic [7:0] fdt;
    logic [63:0] sw;
    logic [95:0] sb;
    int fail_count = 0;
    int cmp_count = 0;
    int seed = 32'h8A77;
    logic [64:0] q[$]; // form flag and word of each expected answer
    logic [7:0][7:0] flt [NC]; // reference filters
    logic [7:0][7:0] lat [NC]; // reference latched copies
    logic hdr = 1'h0; // reference header flag
    logic [31:0] r;

    always #50 clk = ~clk;

    scf_status_filter #(.N_CONN(NC)) i_scf_status_filter (.clk(clk), .reset(reset),
        .adc_done(ev[0]), .print_timer_expired(ev[1]), .timed_log_timer_expired(ev[2]),
        .meas_drop(ev[3]), .unit_change(ev[4]), .cmd_syntax_err(ev[5]),
        .cmd_exec_err(ev[6]), .chart_paper_out(lv[0]), .card_space_low(lv[1]),
        .chart_feed_active(lv[2]), .basic_setting_mode(lv[3]), .recording_active(lv[4]),
        .computing_active(lv[5]), .alarm_active(lv[6]), .header_print_start(hs),
        .header_print_end(he), .card_saving(lv[7]), .card_replaying(lv[8]),
        .filter_wr(fwr), .filter_conn(fcn), .filter_group(fgr), .filter_data(fdt),
        .status_rd(srd), .status_conn(scn), .status_ext(sext), .status_valid(sval),
        .status_ext_out(sxo), .status_word(sw), .status_bcd(sb));

    scf_host_model #(.CONN_W(CW)) i_scf_host_model (.clk(clk), .filter_wr(fwr),
        .filter_conn(fcn), .filter_group(fgr), .filter_data(fdt), .status_rd(srd),
        .status_conn(scn), .status_ext(sext));

    // this cycle's conditions; unassigned bits left at zero
    function automatic logic [7:0][7:0] cond();
        logic [7:0][7:0] c;
        c = '0;
        c[0] = {4'h0, ev[2], ev[1], 1'h0, ev[0]};
        c[1] = {4'h0, ev[6:3]};
        c[2] = {2'h0, lv[2], 2'h0, lv[1], lv[0], 1'h0};
        c[3] = {1'h0, hdr, 2'h0, lv[6:3]};
        c[6] = {6'h0, lv[8:7]};
        return c;
    endfunction

    // three decimal digits per group byte
    function automatic logic [95:0] bcdw(input logic [7:0][7:0] w);
        logic [95:0] b;
        for (int g = 0; g < 8; g++) begin
            b[12*g +: 12] = {4'(w[g] / 100), 4'((w[g] / 10) % 10), 4'(w[g] % 10)};
        end
        return b;
    endfunction

    // reference model, on the same edges as the design
    always @(posedge clk or posedge reset) begin
        logic [7:0][7:0] c;
        logic [7:0][7:0] v;
        if (reset) begin
            for (int k = 0; k < NC; k++) begin
                flt[k] = {8{8'hFF}};
                lat[k] = '0;
            end
            hdr = 1'h0;
        end else begin
            c = cond();
            if (srd && scn < NC) begin
                for (int g = 0; g < 8; g++) begin
                    // latched copies were filtered on entry, so a filter narrowed
                    // later does not hide what already landed; levels gate at read
                    v[g] = (g inside {0, 1, 4, 5}) ? lat[scn][g] : (c[g] & flt[scn][g]);
                end
                if (!sext) v[7:4] = '0;
                q.push_back({sext, v});
            end
            for (int k = 0; k < NC; k++) begin
                for (int g = 0; g < 8; g++) begin
                    if (g inside {0, 1, 4, 5}) begin
                        if (srd && scn == k) lat[k][g] = '0;
                        lat[k][g] = lat[k][g] | (c[g] & flt[k][g]);
                    end
                end
            end
            if (fwr && fcn < NC) flt[fcn][fgr] = fdt;
            if (hs) hdr = 1'h1;
            else if (he) hdr = 1'h0;
        end
    end

    task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // answer watcher: oldest note against every valid answer
    always @(negedge clk) begin
        logic [64:0] e;
        if (sval === 1'h1) begin
            if (q.size() == 0) begin
                check("unexpected answer", 96'h1, 96'h0);
            end else begin
                e = q.pop_front();
                check("status_ext_out", {95'h0, sxo}, {95'h0, e[64]});
                check("status_word", {32'h0, sw}, {32'h0, e[63:0]});
                check("status_bcd", sb, bcdw(e[63:0]));
            end
        end
    end

    task automatic pulse(input int i);
        @(negedge clk);
        ev[i] = 1'h1;
        @(negedge clk);
        ev = '0;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset = 1'h0;
        i_scf_host_model.read_status(2'h0, 1'h1);
        for (int i = 0; i < 7; i++) begin // each event once, then cleared
            pulse(i);
            i_scf_host_model.read_status(2'h0, 1'h0);
            i_scf_host_model.read_status(2'h0, 1'h0);
        end
        for (int i = 0; i < 9; i++) begin // each level persists over reads
            lv[i] = 1'h1;
            i_scf_host_model.read_status(2'h1, 1'h1);
            i_scf_host_model.read_status(2'h1, 1'h1);
            lv = '0;
        end
        i_scf_host_model.set_filter(2'h1, 3'h0, 8'h00); // masked event dropped
        pulse(0);
        i_scf_host_model.set_filter(2'h1, 3'h0, 8'hFF);
        i_scf_host_model.read_status(2'h1, 1'h0);
        i_scf_host_model.set_filter(2'h1, 3'h3, 8'h00); // masked level kept
        lv[6] = 1'h1;
        i_scf_host_model.read_status(2'h1, 1'h0);
        i_scf_host_model.set_filter(2'h1, 3'h3, 8'hFF);
        i_scf_host_model.read_status(2'h1, 1'h0);
        lv = '0;
        i_scf_host_model.set_filter(2'h2, 3'h1, 8'h00); // connections apart
        pulse(5);
        i_scf_host_model.read_status(2'h2, 1'h0);
        i_scf_host_model.read_status(2'h0, 1'h0);
        i_scf_host_model.set_filter(2'h2, 3'h1, 8'hFF);
        fork // event in the clearing cycle survives
            i_scf_host_model.read_status(2'h2, 1'h0);
            pulse(3);
        join
        i_scf_host_model.read_status(2'h2, 1'h0);
        @(negedge clk);
        hs = 1'h1; // header window
        @(negedge clk);
        hs = 1'h0;
        i_scf_host_model.read_status(2'h0, 1'h0);
        he = 1'h1;
        @(negedge clk);
        he = 1'h0;
        i_scf_host_model.read_status(2'h0, 1'h0);
        i_scf_host_model.read_status(2'h3, 1'h0); // refused connection index
        i_scf_host_model.set_filter(2'h3, 3'h3, 8'h00);
        i_scf_host_model.set_filter(2'h1, 3'h3, 8'h00); // reset must reopen this filter
        lv = 9'h140; // alarm and card replaying
        i_scf_host_model.read_status(2'h1, 1'h1);
        @(negedge clk);
        reset = 1'h1; // mid-run reset clears answer, filters and copies
        @(negedge clk);
        check("status_valid", {95'h0, sval}, 96'h0);
        check("status_ext_out", {95'h0, sxo}, 96'h0);
        check("status_word", {32'h0, sw}, 96'h0);
        check("status_bcd", sb, 96'h0);
        reset = 1'h0;
        i_scf_host_model.read_status(2'h1, 1'h1);
        lv = '0;
        for (int n = 0; n < 300; n++) begin // random traffic, refused indexes included
            @(negedge clk);
            r = $random(seed);
            ev = r[6:0] & r[13:7];
            lv = r[22:14];
            hs = r[23] & r[24];
            he = r[25] & r[26];
            case (r[29:28])
                2'h0: i_scf_host_model.set_filter(r[31:30], r[10:8], r[7:0]);
                2'h1: i_scf_host_model.read_status(r[31:30], r[27]);
                default: ;
            endcase
        end
        ev = '0;
        hs = 1'h0;
        he = 1'h0;
        repeat (3) @(negedge clk);
        check("answers pending", 96'(q.size()), 96'h0);
        conclude();
    end

    // watchdog, well beyond the expected run of under 2000 cycles
    initial begin
        #2000000;
        fail_count++;
        conclude();
    end
endmodule // tb_top

`default_nettype wire
